// >>> design/fpg_map.svh
/*
  Offsets, field positions, reset values, key codes and address limits for
  the flash program guard. Assumes a byte-wide register port indexed by a
  small address and a 64 KB core address space with a 2-bit code bank.
*/
`ifndef FPG_MAP_SVH
`define FPG_MAP_SVH
`define FPG_REG_PSC      3'h0
`define FPG_REG_KEY      3'h1
`define FPG_REG_SCALE    3'h2
`define FPG_REG_BANK     3'h3
`define FPG_REG_RSRC     3'h4
`define FPG_REG_VMON     3'h5
`define FPG_REG_STAT     3'h6
`define FPG_PSC_WE       0
`define FPG_PSC_EE       1
`define FPG_SCALE_EWT    4
`define FPG_RSRC_FERR    6
`define FPG_VMON_HIGH    0
`define FPG_VMON_RST     1
`define FPG_KEY_FIRST    8'hA5
`define FPG_KEY_SECOND   8'hF1
`define FPG_ERASED       8'hFF
`define FPG_BANK_RST     2'h1
`define FPG_LIMIT_B3     17'h1FBFF
`define FPG_LIMIT_NO_B3  17'h17FFF
`define FPG_PAGE_LSB     9
`endif

// >>> design/fpg_pkg.sv
/*
  Types for the flash program guard: the key sequencer states.
  Assumes the constants header is compiled alongside.
*/
package fpg_pkg;
  typedef enum logic [1:0] {
    FPG_KEY_IDLE = 2'b00,
    FPG_KEY_ONE  = 2'b01,
    FPG_KEY_OPEN = 2'b11,
    FPG_KEY_DEAD = 2'b10
  } fpg_key_t;
endpackage

// >>> design/fpg_top.sv
/*
  Flash program guard: key sequencing, enable gating, lock byte protection,
  illegal-address and supply checks, flash error reset request and flag.
  Assumes a flash array that ANDs programmed data into the cell, a core
  that holds each access strobe for one cycle, and a lock byte input that
  mirrors the last byte of user flash.
*/
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fpg_map.svh"
module fpg_top #(
  parameter bit HAS_BANK3 = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        xd_wr,
  input  wire logic        xd_rd,
  input  wire logic        cm_rd,
  input  wire logic        fetch,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  input  wire logic        exec_locked,
  input  wire logic [7:0]  lock_byte,
  input  wire logic        dbg_req,
  input  wire logic [16:0] dbg_addr,
  output logic             flash_prog,
  output logic             flash_erase,
  output logic             flash_rd,
  output logic             external_data_ram_wr,
  output logic             external_data_ram_rd,
  output logic      [16:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             flash_long_wr,
  output logic             sys_rst_req,
  output logic             rst_pin_oe,
  output logic             dbg_refused
);
  import fpg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  localparam logic [16:0] LIMIT = HAS_BANK3 ? `FPG_LIMIT_B3 : `FPG_LIMIT_NO_B3;
  localparam logic [7:0]  LIM_PAGE = LIMIT[16:`FPG_PAGE_LSB];

  if (LIMIT[`FPG_PAGE_LSB-1:0] != {`FPG_PAGE_LSB{1'b1}}) begin : g_limit_chk
    $error("user limit must end a page");
  end

  // upper half of the core space is banked
  function automatic logic [16:0] lin_addr(input logic [15:0] a, input logic [1:0] b);
    lin_addr = a[15] ? {b, a[14:0]} : {1'b0, a};
  endfunction

  function automatic logic page_locked(input logic [16:0] a, input logic [7:0] lb);
    logic [7:0] pg;
    pg = a[16:`FPG_PAGE_LSB];
    page_locked = (pg < ~lb) || ((pg == LIM_PAGE) && (lb != 8'hFF));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  logic       wr_en;
  logic       er_en;
  logic       ewt;
  logic [1:0] bank;
  logic       ferr;
  logic       vm_high;
  logic       vm_rst;
  fpg_key_t   key;
  fpg_key_t   next_key;

  logic [16:0] lin;
  logic        f_wr;
  logic        f_rd;
  logic        err_range;
  logic        err_sec;
  logic        err_vdd;
  logic        err;
  logic        op_ok;

  always_comb begin
    lin       = lin_addr(core_addr, bank);
    f_wr      = xd_wr && wr_en;
    f_rd      = cm_rd;
    err_range = (f_wr || cm_rd || fetch) && (lin > LIMIT);
    err_sec   = (f_wr || f_rd) && page_locked(lin, lock_byte) && !exec_locked;
    err_vdd   = (f_wr || f_rd) && !(vm_high && vm_rst);
    err       = err_range || err_sec || err_vdd;
    op_ok     = f_wr && !err && (key == FPG_KEY_OPEN);
  end

  //////////////////////////////////////////////////////////////////////////
  wire key_wr = reg_wr && (reg_addr == `FPG_REG_KEY);

  always_comb begin
    next_key = key;
    if (f_wr && !err) begin
      next_key = (key == FPG_KEY_OPEN) ? FPG_KEY_IDLE : FPG_KEY_DEAD;
    end else if (key_wr) begin
      case (key)
        FPG_KEY_IDLE: begin
          next_key = (reg_wdata == `FPG_KEY_FIRST) ? FPG_KEY_ONE : FPG_KEY_DEAD;
        end
        FPG_KEY_ONE: begin
          next_key = (reg_wdata == `FPG_KEY_SECOND) ? FPG_KEY_OPEN : FPG_KEY_DEAD;
        end
        FPG_KEY_OPEN: begin
          next_key = FPG_KEY_DEAD;
        end
        default: begin
          next_key = FPG_KEY_DEAD;
        end
      endcase
    end
  end

  // a flash error resets the key, enables, write time and bank as a system reset would
  always_ff @(posedge clk) begin
    if (!rst_n || err) begin
      key <= FPG_KEY_IDLE;
    end else begin
      key <= next_key;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || err) begin
      wr_en <= 1'b0;
      er_en <= 1'b0;
      ewt   <= 1'b0;
      bank  <= `FPG_BANK_RST;
    end else if (reg_wr) begin
      if (reg_addr == `FPG_REG_PSC) begin
        wr_en <= reg_wdata[`FPG_PSC_WE];
        er_en <= reg_wdata[`FPG_PSC_EE];
      end
      if (reg_addr == `FPG_REG_SCALE) begin
        ewt <= reg_wdata[`FPG_SCALE_EWT];
      end
      if (reg_addr == `FPG_REG_BANK) begin
        bank <= reg_wdata[1:0];
      end
    end
  end

  // supply monitor setting survives a flash error reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vm_high <= 1'b0;
      vm_rst  <= 1'b0;
    end else if (reg_wr && (reg_addr == `FPG_REG_VMON)) begin
      vm_high <= reg_wdata[`FPG_VMON_HIGH];
      vm_rst  <= reg_wdata[`FPG_VMON_RST];
    end
  end

  // flag is read-only; it records the last reset cause
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ferr <= 1'b0;
    end else if (err) begin
      ferr <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FPG_REG_PSC:   reg_rdata <= {6'h00, er_en, wr_en};
        `FPG_REG_KEY:   reg_rdata <= {6'h00, key};
        `FPG_REG_SCALE: reg_rdata <= {3'h0, ewt, 4'h0};
        `FPG_REG_BANK:  reg_rdata <= {6'h00, bank};
        `FPG_REG_RSRC:  reg_rdata <= {1'b0, ferr, 6'h00};
        `FPG_REG_VMON:  reg_rdata <= {6'h00, vm_rst, vm_high};
        `FPG_REG_STAT:  reg_rdata <= {7'h00, page_locked(LIMIT, lock_byte)};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_prog  <= 1'b0;
      flash_erase <= 1'b0;
      flash_rd    <= 1'b0;
      external_data_ram_wr     <= 1'b0;
      external_data_ram_rd     <= 1'b0;
      mem_addr    <= 17'h00000;
      mem_wdata   <= 8'h00;
    end else begin
      flash_prog  <= op_ok && wr_en && !er_en;
      flash_erase <= op_ok && wr_en && er_en;
      flash_rd    <= cm_rd && !err;
      external_data_ram_wr     <= xd_wr && !wr_en;
      external_data_ram_rd     <= xd_rd;
      mem_addr    <= xd_rd || (xd_wr && !wr_en) ? {1'b0, core_addr} : lin;
      // array ANDs the byte in; erase fills the page
      mem_wdata   <= er_en && f_wr ? `FPG_ERASED : core_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_long_wr <= 1'b0;
      sys_rst_req   <= 1'b0;
      rst_pin_oe    <= 1'b0;
      dbg_refused   <= 1'b0;
    end else begin
      flash_long_wr <= ewt;
      sys_rst_req   <= err;
      rst_pin_oe    <= 1'b0;
      dbg_refused   <= dbg_req && page_locked(dbg_addr, lock_byte);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  relock_after_op_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_ok |=> key == FPG_KEY_IDLE)
    else $error("key not relocked after operation");
  dead_stays_a: assert property (@(posedge clk) disable iff (!rst_n)
    key == FPG_KEY_DEAD && !err |=> key == FPG_KEY_DEAD)
    else $error("dead key state left without reset");
  prog_needs_key_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(flash_prog) |-> $past(key) == FPG_KEY_OPEN && $past(wr_en) && !$past(er_en))
    else $error("program without open key and write enable");
  erase_both_en_a: assert property (@(posedge clk) disable iff (!rst_n)
    flash_erase |-> $past(wr_en) && $past(er_en) && mem_wdata == 8'hFF)
    else $error("erase without both enables");
  range_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cm_rd || fetch) && lin > LIMIT |=> sys_rst_req ##1 ferr)
    else $error("out of range read gave no reset");
  supply_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    cm_rd && !(vm_high && vm_rst) |=> sys_rst_req && !flash_rd)
    else $error("supply check did not reset");
  lock_page_a: assert property (@(posedge clk) disable iff (!rst_n)
    dbg_req && dbg_addr[16:9] == LIM_PAGE && lock_byte != 8'hFF |=> dbg_refused)
    else $error("lock byte page not locked");
  external_data_ram_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    xd_rd |=> external_data_ram_rd && !flash_rd)
    else $error("data read did not go to external ram");
  err_clears_en_a: assert property (@(posedge clk) disable iff (!rst_n)
    sys_rst_req |-> !wr_en && !er_en && ferr && !rst_pin_oe)
    else $error("error reset left state behind");

  key_open_c: cover property (@(posedge clk) disable iff (!rst_n) key == FPG_KEY_OPEN);
  prog_c:     cover property (@(posedge clk) disable iff (!rst_n) flash_prog);
  erase_c:    cover property (@(posedge clk) disable iff (!rst_n) flash_erase);
  err_c:      cover property (@(posedge clk) disable iff (!rst_n) sys_rst_req);
endmodule
`default_nettype wire

// >>> test/fpg_core_model.sv
/*
  Core model for the flash program guard: issues data writes, data reads,
  code-move reads and fetch checks, one strobe per access.
  Assumes a bench that raises go for one cycle with op, addr and data.
*/
`timescale 1ns/1ps
`default_nettype none
module fpg_core_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [1:0]  op,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data,
  output logic             xd_wr,
  output logic             xd_rd,
  output logic             cm_rd,
  output logic             fetch,
  output logic      [15:0] core_addr,
  output logic      [7:0]  core_wdata
);
  initial {xd_wr, xd_rd, cm_rd, fetch, core_addr, core_wdata} = '0;
  // idle bus shows inverted values so stale data never passes
  always @(posedge clk) begin
    {fetch, cm_rd, xd_rd, xd_wr} <= go ? 4'h1 << op : 4'h0;
    core_addr <= go ? addr : ~core_addr;
    core_wdata <= go ? data : ~core_wdata;
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
/*
  Bench for the flash program guard: a table of keyed writes and erases,
  then hand tests for routing, range, supply, lock and key faults.
  Assumes the design files and the core model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpg_map.svh"
module tb_top;
  typedef struct packed {
    logic [1:0]  bank;
    logic [1:0]  psc;
    logic [15:0] a;
    logic [7:0]  lock;
    logic [5:0]  exp;
  } fpg_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  reg_addr = '0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, exec_locked = 1'b0, dbg_req = 1'b0;
  logic [1:0]  op = '0;
  logic [15:0] c_addr = '0, core_addr;
  logic [7:0]  reg_wdata = '0, c_data = '0, lock_byte = 8'hFF, reg_rdata, core_wdata, mem_wdata;
  logic [16:0] dbg_addr = '0, mem_addr;
  logic        xd_wr, xd_rd, cm_rd, fetch, flash_prog, flash_erase, flash_rd, external_data_ram_wr;
  logic        external_data_ram_rd, flash_long_wr, sys_rst_req, rst_pin_oe, dbg_refused;
  logic        nb_rst, seen_long, seen_nb;
  logic [16:0] seen_addr;
  logic [7:0]  seen_wdata;
  int          err_total = 0, checks = 0, cyc = 0;
  // result bits: prog erase flash_rd external_data_ram_wr external_data_ram_rd reset
  fpg_row_t    rows [9] = '{'{2'h1, 2'h1, 16'h1234, 8'hFF, 6'h20},
    '{2'h1, 2'h3, 16'h0200, 8'hFF, 6'h10}, '{2'h3, 2'h1, 16'hFBFF, 8'hFF, 6'h20},
    '{2'h3, 2'h1, 16'hFC00, 8'hFF, 6'h01}, '{2'h2, 2'h1, 16'h8000, 8'hFE, 6'h20},
    '{2'h1, 2'h1, 16'h0100, 8'hFE, 6'h01}, '{2'h1, 2'h3, 16'h0200, 8'hFE, 6'h10},
    '{2'h1, 2'h1, 16'h03FF, 8'hFD, 6'h01}, '{2'h3, 2'h1, 16'hFA00, 8'hFE, 6'h01}};

  fpg_top #(.HAS_BANK3(1'b1)) uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .xd_wr, .xd_rd, .cm_rd, .fetch, .core_addr, .core_wdata, .exec_locked,
    .lock_byte, .dbg_req, .dbg_addr, .flash_prog, .flash_erase, .flash_rd, .external_data_ram_wr,
    .external_data_ram_rd, .mem_addr, .mem_wdata, .flash_long_wr, .sys_rst_req, .rst_pin_oe, .dbg_refused);
  fpg_core_model core_m (.clk, .go, .op, .addr(c_addr), .data(c_data), .xd_wr, .xd_rd,
    .cm_rd, .fetch, .core_addr, .core_wdata);
  // second build without bank three, watched only for its range reset
  fpg_top #(.HAS_BANK3(1'b0)) uut_nb (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(), .xd_wr, .xd_rd, .cm_rd, .fetch, .core_addr, .core_wdata, .exec_locked,
    .lock_byte, .dbg_req, .dbg_addr, .flash_prog(), .flash_erase(), .flash_rd(), .external_data_ram_wr(),
    .external_data_ram_rd(), .mem_addr(), .mem_wdata(), .flash_long_wr(), .sys_rst_req(nb_rst),
    .rst_pin_oe(), .dbg_refused());

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk);
  endtask
  task automatic core(input logic [1:0] o, input logic [15:0] a, input logic [5:0] exp);
    op <= o;
    c_addr <= a;
    c_data <= 8'h5A;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    @(posedge clk) #1;
    chk({flash_prog, flash_erase, flash_rd, external_data_ram_wr, external_data_ram_rd, sys_rst_req}, exp);
    seen_addr = mem_addr;
    seen_wdata = mem_wdata;
    seen_long = flash_long_wr;
    seen_nb = nb_rst;
    @(posedge clk);
  endtask
  task automatic dbg(input logic [16:0] a, input logic e);
    dbg_addr <= a;
    dbg_req <= 1'b1;
    @(posedge clk) dbg_req <= 1'b0;
    #1 chk(dbg_refused, e);
    @(posedge clk);
  endtask
  // full keyed access: bank, long write time, enables, both keys, one write
  task automatic keyed(input logic [1:0] b, input logic [1:0] p, input logic [15:0] a,
                       input logic [5:0] exp);
    wr(`FPG_REG_BANK, {6'h0, b});
    wr(`FPG_REG_SCALE, 8'h10);
    wr(`FPG_REG_PSC, {6'h0, p});
    wr(`FPG_REG_KEY, `FPG_KEY_FIRST);
    wr(`FPG_REG_KEY, `FPG_KEY_SECOND);
    core(2'd0, a, exp);
  endtask
  function automatic logic [16:0] lin(input logic [1:0] b, input logic [15:0] a);
    return a[15] ? {b, a[14:0]} : {1'b0, a};
  endfunction
  task automatic test_done;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`FPG_REG_BANK, 8'h01);
    rd(`FPG_REG_RSRC, 8'h00);
    core(2'd2, 16'h0100, 6'h01);
    rd(`FPG_REG_RSRC, 8'h40);
    chk(rst_pin_oe, 1'b0);
    wr(`FPG_REG_VMON, 8'h03);
    // pages are taken as erased; program rows and erase rows are interleaved
    foreach (rows[i]) begin
      lock_byte <= rows[i].lock;
      keyed(rows[i].bank, rows[i].psc, rows[i].a, rows[i].exp);
      if (!rows[i].exp[0]) begin
        chk(seen_addr, lin(rows[i].bank, rows[i].a));
        chk(seen_wdata, rows[i].exp[4] ? `FPG_ERASED : 8'h5A);
        chk(seen_long, 1'b1);
      end
    end
    $display("done: table");
    lock_byte <= 8'hFF;
    core(2'd1, 16'h1234, 6'h02);
    chk(seen_addr, 17'h01234);
    core(2'd2, 16'h1234, 6'h08);
    wr(`FPG_REG_PSC, 8'h02);
    core(2'd0, 16'h0010, 6'h04);
    wr(`FPG_REG_BANK, 8'h03);
    core(2'd2, 16'hFC00, 6'h01);
    wr(`FPG_REG_BANK, 8'h03);
    core(2'd3, 16'hFBFF, 6'h00);
    chk(seen_nb, 1'b1);
    core(2'd3, 16'hFC00, 6'h01);
    wr(`FPG_REG_VMON, 8'h01);
    core(2'd2, 16'h1234, 6'h01);
    wr(`FPG_REG_VMON, 8'h03);
    $display("done: routing and range");
    lock_byte <= 8'hFE;
    rd(`FPG_REG_STAT, 8'h01);
    core(2'd2, 16'h0100, 6'h01);
    exec_locked <= 1'b1;
    core(2'd2, 16'h0100, 6'h08);
    exec_locked <= 1'b0;
    dbg(17'h00100, 1'b1);
    dbg(17'h1FA00, 1'b1);
    dbg(17'h00200, 1'b0);
    lock_byte <= 8'hFF;
    rd(`FPG_REG_STAT, 8'h00);
    $display("done: lock");
    keyed(2'h1, 2'h1, 16'h0400, 6'h20);
    core(2'd0, 16'h0401, 6'h00);
    rd(`FPG_REG_KEY, 8'h02);
    keyed(2'h1, 2'h1, 16'h0402, 6'h00);
    rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk);
    rd(`FPG_REG_RSRC, 8'h00);
    wr(`FPG_REG_KEY, `FPG_KEY_SECOND);
    rd(`FPG_REG_KEY, 8'h02);
    rd(3'h7, 8'h00);
    $display("done: keys");
    test_done;
  end
endmodule
`default_nettype wire
